//--- shared/sfcfe_defs.vh
/*
  front end constants: opcodes, engine kinds, geometry.
  assumes inclusion by bare name.
*/
`ifndef SFCFE_DEFS_VH
`define SFCFE_DEFS_VH

// array access opcodes
`define SFCFE_OP_READ_S      8'h03
`define SFCFE_OP_FREAD_S     8'h0B
`define SFCFE_OP_READ_L      8'h13
`define SFCFE_OP_FREAD_L     8'h0C
`define SFCFE_OP_PROG_S      8'h02
`define SFCFE_OP_PROG_L      8'h12
`define SFCFE_OP_SERASE_S    8'h20
`define SFCFE_OP_SERASE_L    8'h21
`define SFCFE_OP_BERASE_S    8'hD8
`define SFCFE_OP_BERASE_L    8'hDC
`define SFCFE_OP_CERASE_A    8'h60
`define SFCFE_OP_CERASE_B    8'hC7
// device operation opcodes
`define SFCFE_OP_SET_WL      8'h06
`define SFCFE_OP_CLR_WL      8'h04
`define SFCFE_OP_PSCHEME     8'h68
`define SFCFE_OP_SUSPEND     8'hB0
`define SFCFE_OP_RESUME      8'h30
`define SFCFE_OP_PDOWN       8'hB9
`define SFCFE_OP_PDREL       8'hAB
`define SFCFE_OP_NOP         8'h00
`define SFCFE_OP_RST_ARM     8'h66
`define SFCFE_OP_RST_EXE     8'h99
`define SFCFE_OP_GLOCK       8'h7E
`define SFCFE_OP_GUNLOCK     8'h98
`define SFCFE_OP_WR_SEC      8'h2F
`define SFCFE_OP_SEC_ENTER   8'hB1
`define SFCFE_OP_SEC_EXIT    8'hC1

// operation kinds on o_cmd_kind
`define SFCFE_K_READ         4'h1
`define SFCFE_K_PROG_BEGIN   4'h2
`define SFCFE_K_PROG_COMMIT  4'h3
`define SFCFE_K_PROG_ABORT   4'h4
`define SFCFE_K_ERASE_SECT   4'h5
`define SFCFE_K_ERASE_BLK    4'h6
`define SFCFE_K_ERASE_CHIP   4'h7
`define SFCFE_K_SUSPEND      4'h8
`define SFCFE_K_RESUME       4'h9
`define SFCFE_K_RESET        4'hA
`define SFCFE_K_GANG_LOCK    4'hB
`define SFCFE_K_GANG_UNLOCK  4'hC
`define SFCFE_K_PSCHEME      4'hD

// geometry and phase lengths
`define SFCFE_BLOCKS         10'h200
`define SFCFE_BLK_MSB        24
`define SFCFE_BLK_LSB        16
`define SFCFE_OTP_RANGE_BIT  9
`define SFCFE_DUMMY_LAST     3'h7
`define SFCFE_LVL_ALL        4'hA

`endif

//--- verilog/sfcfe_sync.v
/*
  two flip-flop synchroniser for independent pin levels.
  assumes slow levels; no word coherence.
*/
`timescale 1ns/100ps
module sfcfe_sync #(
  parameter       W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         i_clk,
  input  wire         i_resetn,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_q;   // first stage, read only by second stage
  reg [W-1:0] sync_q;   // second stage, safe to use

  // plain two-stage chain
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule

//--- verilog/sfcfe_prot.v
/*
  block protection decode from level code and anchor.
  assumes a 512-block array.
*/
`timescale 1ns/100ps
`include "sfcfe_defs.vh"
module sfcfe_prot (
  input  wire [3:0] i_level,
  input  wire       i_bottom_select,
  input  wire [8:0] i_block,
  output wire       o_protected,
  output wire       o_any
);
  // number of protected blocks for a level code
  function [9:0] prot_count;
    input [3:0] lvl;
    begin
      if (lvl == 4'h0)
        prot_count = 10'h000;  // R2
      else if (lvl >= `SFCFE_LVL_ALL)
        prot_count = `SFCFE_BLOCKS;  // R2
      else
        prot_count = 10'h001 << (lvl - 4'h1);  // R1
    end
  endfunction

  wire [9:0] cnt = prot_count(i_level);
  wire [9:0] blk = {1'b0, i_block};

  // bottom anchor covers low blocks, otherwise the top ones
  assign o_protected = i_bottom_select ? (blk < cnt)              // R1
                                       : (blk >= (`SFCFE_BLOCKS - cnt));
  assign o_any       = (cnt != 10'h000);
endmodule

//--- verilog/sfcfe_top.v
/*
  serial nor flash command front end, device side:
  decodes single line opcodes,
  hands array work to an engine,
  keeps latch, modes and customer lock.
  assumes async pins, serial clock
  at least 8 times slower than i_clk;
  the engine runs on i_clk.
*/
// Operation
// [R1] bottom anchor, level n protects 2^(n-1) low blocks
// [R2] level 0 none, levels 10-15 all blocks
// [R3] 8K-bit one-time area for serial number
// [R4] security bit 0 shows factory lock
// [R5] security write sets customer lock bit 1
// [R6] locked one-time range never changes again
// [R7] secured mode refuses main array access
// [R8] host enters secured mode, programs, then exits
// [R9] invalid sequence: standby, output off until frame
// [R10] valid sequence: active until chip select rises
// [R11] single edge: sample rising, launch falling
// [R12] double edge: sample and launch both edges
// [R13] array access ignored while operation running
// [R14] host checks status before each command
// [R15] read opcodes 03 0B 13 0C decoded
// [R16] program opcodes 02 and 12 decoded
// [R17] erase opcodes 20 21 D8 DC decoded
// [R18] chip erase under 60 or C7
// [R19] latch set 06, clear 04, scheme 68
// [R20] suspend B0, resume 30
// [R21] power down B9, release AB, nop 00
// [R22] reset arm 66, execute 99, gang 7E/98
// [R23] reset execute only directly after reset arm
// [R24] power down refuses all but release, reset
// [R25] secured mode enter B1, exit C1
// [R26] data changes need write latch set
// [R27] program or erase of protected blocks refused
`timescale 1ns/100ps
`include "sfcfe_defs.vh"
module sfcfe_top (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        i_cs_n,             // chip select pin, active low
  input  wire        i_sclk,             // serial clock pin
  input  wire        i_si,               // serial data in pin
  input  wire        i_single_edge_mode, // 1 single edge, 0 double edge
  input  wire [3:0]  i_protect_level,    // protect-level code
  input  wire        i_bottom_select,    // protection anchored at block 0
  input  wire        i_busy,             // array engine running an operation
  input  wire        i_factory_lock,     // factory range locked
  input  wire [7:0]  i_rd_data,          // read byte from array engine
  output wire        o_so,
  output wire        o_so_oe,
  output wire        o_cmd_pulse,
  output wire [3:0]  o_cmd_kind,
  output wire [31:0] o_cmd_addr,
  output wire        o_cmd_secured,
  output wire        o_wr_strobe,
  output wire [7:0]  o_wr_data,
  output wire        o_rd_next,
  output wire        o_active,
  output wire        o_write_latch_bit,
  output wire        o_secured_mode,
  output wire        o_power_down,
  output wire        o_reset_armed,
  output wire [7:0]  o_security_reg
);
  // frame states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPC   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_DUMMY = 3'h3;
  localparam [2:0] ST_DIN   = 3'h4;
  localparam [2:0] ST_DOUT  = 3'h5;
  localparam [2:0] ST_BARE  = 3'h6;
  localparam [2:0] ST_STBY  = 3'h7;

  // opcode classes
  localparam [1:0] CL_READ  = 2'h0;
  localparam [1:0] CL_PROG  = 2'h1;
  localparam [1:0] CL_ERASE = 2'h2;
  localparam [1:0] CL_BARE  = 2'h3;

  // decode: {known, long address, dummy, class}
  function [4:0] opc_info;
    input [7:0] opc;
    begin
      case (opc)
        `SFCFE_OP_READ_S:   opc_info = {3'b100, CL_READ};   // R15
        `SFCFE_OP_FREAD_S:  opc_info = {3'b101, CL_READ};   // R15
        `SFCFE_OP_READ_L:   opc_info = {3'b110, CL_READ};   // R15
        `SFCFE_OP_FREAD_L:  opc_info = {3'b111, CL_READ};   // R15
        `SFCFE_OP_PROG_S:   opc_info = {3'b100, CL_PROG};   // R16
        `SFCFE_OP_PROG_L:   opc_info = {3'b110, CL_PROG};   // R16
        `SFCFE_OP_SERASE_S,
        `SFCFE_OP_BERASE_S: opc_info = {3'b100, CL_ERASE};  // R17
        `SFCFE_OP_SERASE_L,
        `SFCFE_OP_BERASE_L: opc_info = {3'b110, CL_ERASE};  // R17
        `SFCFE_OP_CERASE_A, `SFCFE_OP_CERASE_B,             // R18
        `SFCFE_OP_SET_WL, `SFCFE_OP_CLR_WL, `SFCFE_OP_PSCHEME, // R19
        `SFCFE_OP_SUSPEND, `SFCFE_OP_RESUME,                // R20
        `SFCFE_OP_PDOWN, `SFCFE_OP_PDREL, `SFCFE_OP_NOP,    // R21
        `SFCFE_OP_RST_ARM, `SFCFE_OP_RST_EXE,
        `SFCFE_OP_GLOCK, `SFCFE_OP_GUNLOCK,                 // R22
        `SFCFE_OP_WR_SEC,
        `SFCFE_OP_SEC_ENTER, `SFCFE_OP_SEC_EXIT:            // R25
                            opc_info = {3'b100, CL_BARE};
        default:            opc_info = {3'b000, CL_BARE};
      endcase
    end
  endfunction

  // synchronised pins, chip select idles high
  wire [2:0] pins_s;
  sfcfe_sync #(.W(3), .RST(3'b100)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      ({i_cs_n, i_sclk, i_si}),
    .o_q      (pins_s)
  );
  wire cs_s   = pins_s[2];
  wire sclk_s = pins_s[1];
  wire si_s   = pins_s[0];

  reg        cs_d_q;      // previous synced chip select
  reg        sclk_d_q;    // previous synced serial clock
  reg [2:0]  st_q;        // frame state
  reg [2:0]  bit_cnt_q;   // bit within byte, shared by all phases but output
  reg [1:0]  byte_cnt_q;  // address byte index
  reg [7:0]  sh_in_q;     // input shifter
  reg [7:0]  opc_q;       // current opcode
  reg [4:0]  info_q;      // decode of current opcode
  reg [31:0] addr_q;      // assembled address
  reg        got_data_q;  // program frame has at least one byte
  reg [7:0]  sh_out_q;    // output shifter
  reg [2:0]  out_cnt_q;   // output bit index
  reg        so_q;
  reg        cmd_pulse_q;
  reg [3:0]  cmd_kind_q;
  reg        wr_strobe_q;
  reg [7:0]  wr_data_q;
  reg        rd_next_q;
  reg        wl_q;        // write latch
  reg        sec_q;       // secured area mode
  reg        pd_q;        // deep power-down
  reg        arm_q;       // reset armed
  reg        cust_lock_q; // customer range lock

  // edges of the synced link signals
  wire cs_fall = ~cs_s & cs_d_q;
  wire cs_rise = cs_s & ~cs_d_q;
  wire sc_rise = sclk_s & ~sclk_d_q;
  wire sc_fall = ~sclk_s & sclk_d_q;
  wire in_frame = ~cs_s & ~cs_d_q;
  // single edge samples rising only, double edge takes both
  wire sample = in_frame & (i_single_edge_mode ? sc_rise : (sc_rise | sc_fall)); // R11 R12
  wire launch = in_frame & (i_single_edge_mode ? sc_fall : (sc_rise | sc_fall)); // R11 R12

  wire        byte_done = (bit_cnt_q == 3'h7);
  wire [7:0]  byte_in   = {sh_in_q[6:0], si_s};
  wire [31:0] addr_full = {addr_q[23:0], byte_in};
  wire [1:0]  addr_last = info_q[3] ? 2'h3 : 2'h2;
  wire [4:0]  info_in   = opc_info(byte_in);

  // protection of the block being addressed
  wire blk_prot;
  wire prot_any;
  sfcfe_prot u_prot (
    .i_level         (i_protect_level),
    .i_bottom_select (i_bottom_select),
    .i_block         (addr_full[`SFCFE_BLK_MSB:`SFCFE_BLK_LSB]),
    .o_protected     (blk_prot),
    .o_any           (prot_any)
  );

  // one-time area: low half customer, high half factory
  wire otp_locked = addr_full[`SFCFE_OTP_RANGE_BIT] ? i_factory_lock : cust_lock_q; // R5 R6
  // secured program hits the one-time area
  wire prog_ok  = wl_q & ~i_busy & (sec_q ? ~otp_locked : ~blk_prot);  // R8 R26 R13 R6 R27
  wire erase_ok = wl_q & ~i_busy & ~sec_q & ~blk_prot;                 // R26 R13 R7 R27
  wire chg_ok   = wl_q & ~i_busy;                                      // R26 R13

  // data-changing bare opcodes checked at decode
  function bare_ok;
    input [7:0] opc;
    begin
      case (opc)
        `SFCFE_OP_CERASE_A,
        `SFCFE_OP_CERASE_B: bare_ok = chg_ok & ~sec_q & ~prot_any;    // R7 R27
        `SFCFE_OP_WR_SEC,
        `SFCFE_OP_GLOCK,
        `SFCFE_OP_GUNLOCK,
        `SFCFE_OP_PSCHEME:  bare_ok = chg_ok;                         // R26
        `SFCFE_OP_RST_EXE:  bare_ok = arm_q;                          // R23
        default:            bare_ok = 1'b1;
      endcase
    end
  endfunction

  // power-down passes release and reset only
  wire pd_pass = (byte_in == `SFCFE_OP_PDREL) | (byte_in == `SFCFE_OP_RST_ARM) |
                 (byte_in == `SFCFE_OP_RST_EXE);                       // R24

  // edge history
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_d_q   <= 1'b1;
      sclk_d_q <= 1'b0;                 // idle level, no false edge
    end else begin
      cs_d_q   <= cs_s;
      sclk_d_q <= sclk_s;
    end
  end

  // frame sequencer and command state
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q        <= ST_IDLE;
      bit_cnt_q   <= 3'h0;
      byte_cnt_q  <= 2'h0;
      sh_in_q     <= 8'h00;
      opc_q       <= 8'h00;
      info_q      <= 5'h00;
      addr_q      <= 32'h0000_0000;
      got_data_q  <= 1'b0;
      cmd_pulse_q <= 1'b0;
      cmd_kind_q  <= 4'h0;
      wr_strobe_q <= 1'b0;
      wr_data_q   <= 8'h00;
      wl_q        <= 1'b0;
      sec_q       <= 1'b0;
      pd_q        <= 1'b0;
      arm_q       <= 1'b0;
      cust_lock_q <= 1'b0;
    end else begin
      cmd_pulse_q <= 1'b0;
      wr_strobe_q <= 1'b0;
      if (cs_fall) begin
        // fresh frame, standby ends here
        st_q       <= ST_OPC;                                          // R9
        bit_cnt_q  <= 3'h0;
        byte_cnt_q <= 2'h0;
        addr_q     <= 32'h0000_0000;
        got_data_q <= 1'b0;
      end else if (cs_rise) begin
        // bare and erase need an exact length
        if (st_q == ST_BARE && bit_cnt_q == 3'h0) begin
          case (opc_q)
            `SFCFE_OP_SET_WL:   wl_q <= 1'b1;  // R26
            `SFCFE_OP_CLR_WL:   wl_q <= 1'b0;  // R19
            `SFCFE_OP_PDOWN:    pd_q <= 1'b1;  // R21
            `SFCFE_OP_PDREL:    pd_q <= 1'b0;  // R21
            `SFCFE_OP_SEC_ENTER: sec_q <= 1'b1;  // R25
            `SFCFE_OP_SEC_EXIT: sec_q <= 1'b0;  // R25
            `SFCFE_OP_RST_ARM:  arm_q <= 1'b1;  // R23
            `SFCFE_OP_WR_SEC: begin
              cust_lock_q <= 1'b1;  // R5 R6
              wl_q        <= 1'b0;
            end
            `SFCFE_OP_RST_EXE: begin
              // software reset drops the volatile modes
              wl_q        <= 1'b0;
              sec_q       <= 1'b0;
              pd_q        <= 1'b0;
              arm_q       <= 1'b0;
              cmd_pulse_q <= 1'b1;
              cmd_kind_q  <= `SFCFE_K_RESET;  // R22
            end
            `SFCFE_OP_SUSPEND, `SFCFE_OP_RESUME: begin
              cmd_pulse_q <= 1'b1;  // R20
              cmd_kind_q  <= (opc_q == `SFCFE_OP_SUSPEND) ? `SFCFE_K_SUSPEND : `SFCFE_K_RESUME;
            end
            `SFCFE_OP_GLOCK, `SFCFE_OP_GUNLOCK, `SFCFE_OP_PSCHEME: begin
              wl_q        <= 1'b0;
              cmd_pulse_q <= 1'b1;  // R22 R19
              cmd_kind_q  <= (opc_q == `SFCFE_OP_GLOCK)   ? `SFCFE_K_GANG_LOCK :
                             (opc_q == `SFCFE_OP_GUNLOCK) ? `SFCFE_K_GANG_UNLOCK : `SFCFE_K_PSCHEME;
            end
            `SFCFE_OP_CERASE_A, `SFCFE_OP_CERASE_B: begin
              wl_q        <= 1'b0;
              cmd_pulse_q <= 1'b1;  // R18
              cmd_kind_q  <= `SFCFE_K_ERASE_CHIP;
            end
            `SFCFE_OP_SERASE_S, `SFCFE_OP_SERASE_L,
            `SFCFE_OP_BERASE_S, `SFCFE_OP_BERASE_L: begin
              wl_q        <= 1'b0;
              cmd_pulse_q <= 1'b1;  // R17
              cmd_kind_q  <= (opc_q == `SFCFE_OP_SERASE_S || opc_q == `SFCFE_OP_SERASE_L) ?
                             `SFCFE_K_ERASE_SECT : `SFCFE_K_ERASE_BLK;
            end
            default: ;  // nop does nothing
          endcase
        end else if (st_q == ST_DIN) begin
          // partial byte or empty page aborts the begun program
          cmd_pulse_q <= 1'b1;
          cmd_kind_q  <= (got_data_q && bit_cnt_q == 3'h0) ? `SFCFE_K_PROG_COMMIT : `SFCFE_K_PROG_ABORT; // R16
          if (got_data_q && bit_cnt_q == 3'h0)
            wl_q <= 1'b0;
        end
        st_q <= ST_IDLE;                                               // R10
      end else if (sample) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        sh_in_q   <= byte_in;
        case (st_q)
          ST_OPC: if (byte_done) begin
            opc_q  <= byte_in;
            info_q <= info_in;
            // other opcodes disarm
            if (byte_in != `SFCFE_OP_RST_ARM)
              arm_q <= 1'b0;  // R23
            if (!info_in[4] || (pd_q && !pd_pass))
              st_q <= ST_STBY;  // R9 R24
            else if (info_in[1:0] == CL_BARE)
              st_q <= bare_ok(byte_in) ? ST_BARE : ST_STBY;  // R9 R26
            else
              st_q <= ST_ADDR;
          end
          ST_ADDR: if (byte_done) begin
            addr_q     <= addr_full;
            byte_cnt_q <= byte_cnt_q + 2'h1;
            if (byte_cnt_q == addr_last) begin
              case (info_q[1:0])
                CL_READ: begin
                  if (i_busy)
                    st_q <= ST_STBY;  // R13
                  else begin
                    st_q <= info_q[2] ? ST_DUMMY : ST_DOUT;  // R15
                    cmd_pulse_q <= 1'b1;
                    cmd_kind_q  <= `SFCFE_K_READ;
                  end
                end
                CL_PROG: begin
                  st_q        <= prog_ok ? ST_DIN : ST_STBY;  // R27 R6
                  cmd_pulse_q <= prog_ok;
                  cmd_kind_q  <= `SFCFE_K_PROG_BEGIN;
                end
                default: st_q <= erase_ok ? ST_BARE : ST_STBY;  // R27 R7
              endcase
            end
          end
          ST_DUMMY: if (bit_cnt_q == `SFCFE_DUMMY_LAST)
            st_q <= ST_DOUT;  // R15
          ST_DIN: if (byte_done) begin
            wr_strobe_q <= 1'b1;
            wr_data_q   <= byte_in;
            got_data_q  <= 1'b1;
          end
          ST_BARE: st_q <= ST_STBY;  // R9
          default: ;  // out and standby ignore input
        endcase
      end
    end
  end

  // serial output, engine byte per boundary
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_out_q  <= 8'h00;
      out_cnt_q <= 3'h0;
      so_q      <= 1'b0;
      rd_next_q <= 1'b0;
    end else begin
      rd_next_q <= 1'b0;
      if (cs_fall) begin
        out_cnt_q <= 3'h0;
      end else if (launch && st_q == ST_DOUT) begin
        out_cnt_q <= out_cnt_q + 3'h1;
        if (out_cnt_q == 3'h0) begin
          so_q      <= i_rd_data[7];                                   // R11 R12
          sh_out_q  <= {i_rd_data[6:0], 1'b0};
          rd_next_q <= 1'b1;
        end else begin
          so_q     <= sh_out_q[7];
          sh_out_q <= {sh_out_q[6:0], 1'b0};
        end
      end
    end
  end

  assign o_so              = so_q;
  assign o_so_oe           = (st_q == ST_DOUT) & ~cs_s;                // R9
  assign o_cmd_pulse       = cmd_pulse_q;
  assign o_cmd_kind        = cmd_kind_q;
  assign o_cmd_addr        = addr_q;
  assign o_cmd_secured     = sec_q;                                    // R3 R7
  assign o_wr_strobe       = wr_strobe_q;
  assign o_wr_data         = wr_data_q;
  assign o_rd_next         = rd_next_q;
  assign o_active          = (st_q != ST_IDLE) & (st_q != ST_STBY);    // R10
  assign o_write_latch_bit = wl_q;
  assign o_secured_mode    = sec_q;
  assign o_power_down      = pd_q;
  assign o_reset_armed     = arm_q;
  assign o_security_reg    = {6'h00, cust_lock_q, i_factory_lock};     // R4 R5
endmodule

//--- testbench/sfcfe_host_model.sv
/*
  host model: drives chip select, serial clock, data in.
  assumes single edge mode, 160 ns clock.
*/
`timescale 1ns/100ps
module sfcfe_host_model (
  output logic o_cs_n,  // chip select, active low
  output logic o_sclk,  // serial clock, still between frames
  output logic o_si,    // data towards the device
  input  wire  i_so     // data from the device
);
  // idle pins at time zero
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si   = 1'b0;
  end
  // select, then leave sync time before the first edge
  task automatic open_frame();
    o_cs_n = 1'b0;
    #160;
  endtask
  // one byte msb first; reads before each fall
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      o_si = b[i];
      #80 o_sclk = 1'b1;
      #80 r = {r[6:0], i_so};
      o_sclk = 1'b0;
    end
  endtask
  // deselect; data line flips so stale bits show
  task automatic close_frame();
    #160 o_cs_n = 1'b1;
    o_si = ~o_si;
    #400;
  endtask
endmodule

//--- testbench/sfcfe_checker_asserts.sv
/*
  checker bound to the front end top.
  assumes one clock domain.
*/
`timescale 1ns/100ps
`include "sfcfe_defs.vh"
module sfcfe_checker (
  input wire        i_clk,
  input wire        i_resetn,
  input wire        i_cs_n,
  input wire        i_busy,
  input wire [3:0]  i_protect_level,
  input wire        i_factory_lock,
  input wire        o_so_oe,
  input wire        o_cmd_pulse,
  input wire [3:0]  o_cmd_kind,
  input wire        o_cmd_secured,
  input wire        o_write_latch_bit,
  input wire        o_power_down,
  input wire [7:0]  o_security_reg
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // any of the three erase kinds
  wire erase_k = (o_cmd_kind == `SFCFE_K_ERASE_SECT) || (o_cmd_kind == `SFCFE_K_ERASE_BLK) ||
                 (o_cmd_kind == `SFCFE_K_ERASE_CHIP);
  // array access kinds that must never overlap a running operation
  wire access_k = erase_k || (o_cmd_kind == `SFCFE_K_READ) || (o_cmd_kind == `SFCFE_K_PROG_BEGIN);
  a_oe_off_idle: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("output enabled outside a frame");
  a_erase_needs_wl: assert property (o_cmd_pulse && erase_k |-> $past(o_write_latch_bit))
    else $error("erase without write latch");
  a_erase_clears_wl: assert property (o_cmd_pulse && erase_k |-> ##[0:1] !o_write_latch_bit)
    else $error("write latch kept after erase");
  a_busy_refuse: assert property (o_cmd_pulse && access_k |-> !$past(i_busy))
    else $error("array access while busy");
  a_secure_no_erase: assert property (o_cmd_pulse && erase_k |-> !o_cmd_secured)
    else $error("erase in secured mode");
  a_chip_prot: assert property (o_cmd_pulse && o_cmd_kind == `SFCFE_K_ERASE_CHIP |-> $past(i_protect_level) == 4'h0)
    else $error("chip erase with protection");
  a_pd_refuse: assert property (o_cmd_pulse && $past(o_power_down) |-> o_cmd_kind == `SFCFE_K_RESET)
    else $error("command in power down");
  a_factory_bit: assert property (o_security_reg[0] == i_factory_lock && o_security_reg[7:2] == 6'h00)
    else $error("security register bits wrong");
  a_lock_sticky: assert property ($past(o_security_reg[1]) |-> o_security_reg[1])
    else $error("customer lock dropped");
endmodule
bind sfcfe_top sfcfe_checker sfcfe_checker_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
  .i_busy(i_busy), .i_protect_level(i_protect_level), .i_factory_lock(i_factory_lock), .o_so_oe(o_so_oe),
  .o_cmd_pulse(o_cmd_pulse), .o_cmd_kind(o_cmd_kind), .o_cmd_secured(o_cmd_secured),
  .o_write_latch_bit(o_write_latch_bit), .o_power_down(o_power_down), .o_security_reg(o_security_reg));

//--- testbench/tb_top.sv
/*
  bench top: host model, scripted engine inputs.
  assumes single edge mode throughout.
*/
`timescale 1ns/100ps
`include "sfcfe_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic        i_clk = 1'b0;     // 50 MHz system clock
  logic        i_resetn = 1'b0;  // held low for 10 cycles
  logic [3:0]  lvl = 4'h0;       // protect-level code
  logic        busy = 1'b0;      // engine busy level
  wire         cs_n, sclk, si, so, oe, pulse, wl, sec, pd;
  wire  [3:0]  kind;
  wire  [31:0] addr;
  wire  [7:0]  sreg;
  logic [3:0]  k_last;           // kind of the latest pulse
  logic [31:0] a_last;           // address of the latest pulse
  logic [7:0]  rd;               // last byte read back by the host
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_pulse = 0;      // pulses seen so far
  always #10 i_clk = ~i_clk;
  sfcfe_host_model sfcfe_host_model_inst (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .i_so(so));
  // engine data, edge mode, anchor tied
  sfcfe_top sfcfe_top_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si),
    .i_single_edge_mode(1'b1), .i_protect_level(lvl), .i_bottom_select(1'b1), .i_busy(busy),
    .i_factory_lock(1'b1), .i_rd_data(8'hA5), .o_so(so), .o_so_oe(oe), .o_cmd_pulse(pulse),
    .o_cmd_kind(kind), .o_cmd_addr(addr), .o_cmd_secured(), .o_wr_strobe(), .o_wr_data(), .o_rd_next(),
    .o_active(), .o_write_latch_bit(wl), .o_secured_mode(sec), .o_power_down(pd), .o_reset_armed(),
    .o_security_reg(sreg));
  // record every command pulse
  always @(posedge i_clk) begin
    if (pulse) begin
      n_pulse <= n_pulse + 1;
      k_last  <= kind;
      a_last  <= addr;
    end
  end
  // one frame: opcode, na address bytes msb first, nd data bytes
  task automatic try(input string nm, input logic [7:0] op, input int na = 0, input logic [31:0] ad = 0,
                     input int nd = 0, input int np = 0, input logic [3:0] ek = 4'h0);
    int n0;
    logic [7:0] r;
    @(posedge i_clk) #1;
    n0 = n_pulse;
    sfcfe_host_model_inst.open_frame();
    sfcfe_host_model_inst.xfer(op, r);
    for (int i = na - 1; i >= 0; i--) sfcfe_host_model_inst.xfer(ad[8*i +: 8], r);
    for (int i = 0; i < nd; i++) sfcfe_host_model_inst.xfer(8'h5A, r);
    rd = r;
    sfcfe_host_model_inst.close_frame();
    `CHK(nm, np, n_pulse - n0)
    if (np > 0) `CHK(nm, ek, k_last)
  endtask
  task automatic set_write_latch_cmd();
    try("latch set", 8'h06);
  endtask
  task automatic t_erase();
    try("erase no latch", 8'h20, 3, 32'h012345);
    set_write_latch_cmd();
    `CHK("latch", 1'b1, wl)
    busy = 1'b1;
    try("erase busy", 8'hD8, 3, 32'h010000);
    busy = 1'b0;
    try("sector", 8'h20, 3, 32'h012345, 0, 1, `SFCFE_K_ERASE_SECT);
    `CHK("sector addr", 32'h00012345, a_last)
    `CHK("latch after erase", 1'b0, wl)
    set_write_latch_cmd();
    try("latch clear", 8'h04);
    `CHK("latch cleared", 1'b0, wl)
    $display("test erase done");
  endtask
  // edge blocks per level; latch set again before each try
  task automatic t_protect();
    logic [3:0] lv[6] = '{4'h1, 4'h1, 4'h9, 4'h9, 4'hA, 4'h0};
    int bk[6] = '{0, 1, 255, 256, 511, 0};
    int ok[6] = '{0, 1, 0, 1, 0, 1};
    for (int i = 0; i < 6; i++) begin
      lvl = lv[i];
      set_write_latch_cmd();
      try("block erase", 8'hDC, 4, bk[i] << 16, 0, ok[i], `SFCFE_K_ERASE_BLK);
    end
    set_write_latch_cmd();
    try("chip 60", 8'h60, 0, 0, 0, 1, `SFCFE_K_ERASE_CHIP);
    set_write_latch_cmd();
    try("chip C7", 8'hC7, 0, 0, 0, 1, `SFCFE_K_ERASE_CHIP);
    set_write_latch_cmd();
    try("gang lock", 8'h7E, 0, 0, 0, 1, `SFCFE_K_GANG_LOCK);
    $display("test protect done");
  endtask
  task automatic t_modes();
    try("arm", 8'h66);
    try("execute", 8'h99, 0, 0, 0, 1, `SFCFE_K_RESET);
    try("arm", 8'h66);
    try("between", 8'h00);
    try("late execute", 8'h99);
    try("suspend", 8'hB0, 0, 0, 0, 1, `SFCFE_K_SUSPEND);
    try("resume", 8'h30, 0, 0, 0, 1, `SFCFE_K_RESUME);
    set_write_latch_cmd();
    try("power down", 8'hB9);
    `CHK("power down", 1'b1, pd)
    try("clear in pd", 8'h04);
    `CHK("latch in pd", 1'b1, wl)
    try("release", 8'hAB);
    `CHK("released", 1'b0, pd)
    try("unknown", 8'hFF);
    try("read 03", 8'h03, 3, 32'h001234, 1, 1, `SFCFE_K_READ);
    `CHK("read addr", 32'h00001234, a_last)
    `CHK("read byte", 8'hA5, rd)
    try("read 0C", 8'h0C, 4, 32'h01000010, 2, 1, `SFCFE_K_READ);
    `CHK("fast byte", 8'hA5, rd)
    $display("test modes done");
  endtask
  // secured area: enter, program, lock, locked program, exit
  task automatic t_otp();
    try("enter", 8'hB1);
    `CHK("secured", 1'b1, sec)
    set_write_latch_cmd();
    try("secured erase", 8'h20, 3);
    try("otp program", 8'h02, 3, 32'h000010, 1, 2, `SFCFE_K_PROG_COMMIT);
    set_write_latch_cmd();
    try("lock", 8'h2F);
    `CHK("security reg", 8'h03, sreg)
    set_write_latch_cmd();
    try("locked program", 8'h02, 3, 32'h000010, 1);
    try("exit", 8'hC1);
    `CHK("secured off", 1'b0, sec)
    $display("test otp done");
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    repeat (5) @(posedge i_clk);
    t_erase();
    t_protect();
    t_modes();
    t_otp();
    results();
  end
  // watchdog, about six times the run
  initial begin
    #1_000_000;
    num_errors++;
    results();
  end
endmodule
